// ==== rtl/pci_pin_pkg.sv ====
// Purpose: shared types and constants for the bus mode pin control block
// Assumes: one clock (core_clk), asynchronous active-low reset
// Notes:   the mode is taken once after reset release from the mode strap inputs
package pci_pin_pkg;

    // ------------------------------------------------------------
    // bus operating modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_HOST_INT_ARB = 2'h0,
        MODE_HOST_EXT_ARB = 2'h1,
        MODE_SATELLITE    = 2'h2
    } bus_mode_type;

    localparam bus_mode_type RESET_MODE = MODE_HOST_INT_ARB;

    // ------------------------------------------------------------
    // reset-sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_STRAP = 3'h1,
        ST_RUN   = 3'h2,
        ST_BUS_RESET = 3'h4
    } seq_state_type;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS        = 5;
    localparam int BUS_RESET_TIME_NS    = 1000;
    localparam int BUS_RESET_CYCLES     =
        (BUS_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_STAGES          = 3;

    // ------------------------------------------------------------
    // two-signal pin drive carrier: output and output enable
    // ------------------------------------------------------------
    typedef struct packed {
        logic o;
        logic oe;
    } pin_drive_type;

    // target-side signalling requests from the device core
    typedef struct packed {
        logic stop;
        logic ready;
        logic sys_error;
    } target_req_type;

endpackage

// ==== rtl/pci_mode_pin_control.sv ====
// Purpose: mode-dependent control of the bus request, reset, system-error,
//          stop and target-ready pins, plus grant pin reuse
// Assumes: pins are sampled through three flip-flops; core requests are
//          synchronous to core_clk
// Notes:   two-way pins appear as input, output and output enable
`timescale 1ns/1ps
`default_nettype none

module pci_mode_pin_control #(
    parameter int BUS_RESET_CYCLES = pci_pin_pkg::BUS_RESET_CYCLES
) (
    // clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       rst_n,
    // mode strap, sampled after reset release
    input  wire logic [1:0]                 mode_strap,
    output logic [1:0]                      bus_mode,
    // core side
    input  wire logic                       core_bus_req,
    input  wire logic                       core_bus_reset,
    input  wire pci_pin_pkg::target_req_type core_target,
    input  wire logic                       core_eeprom_select,
    output logic [1:0]                      arb_request,
    output logic                            core_grant,
    output logic                            config_id_select,
    output logic                            warm_reset_req,
    output logic                            system_error_seen,
    output logic                            bus_stop_seen,
    output logic                            bus_ready_seen,
    // request pins
    input  wire logic [1:0]                 bus_request_n_i,
    output logic [1:0]                      bus_request_n_o,
    output logic [1:0]                      bus_request_n_oe,
    // grant pins (grant 1 doubles as serial eeprom select)
    input  wire logic [1:0]                 bus_grant_n_i,
    input  wire logic [1:0]                 arb_grant,
    output logic [1:0]                      bus_grant_n_o,
    output logic [1:0]                      bus_grant_n_oe,
    // reset pin
    input  wire logic                       bus_reset_n_i,
    output logic                            bus_reset_n_o,
    output logic                            bus_reset_n_oe,
    // system error pin, open drain
    input  wire logic                       system_error_n_i,
    output logic                            system_error_n_o,
    output logic                            system_error_n_oe,
    // target stop and ready pins
    input  wire logic                       target_stop_n_i,
    output logic                            target_stop_n_o,
    output logic                            target_stop_n_oe,
    input  wire logic                       target_ready_n_i,
    output logic                            target_ready_n_o,
    output logic                            target_ready_n_oe,
    // target drive enable, core owns the target role for this transaction
    input  wire logic                       core_target_sel
);

    localparam int NSYNC = 7;

    // ------------------------------------------------------------
    // pin input synchronisers
    // ------------------------------------------------------------
    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] s1_q, s2_q, s3_q, s1_d, s2_d, s3_d;
    logic [NSYNC-1:0] filt_q, filt_d;

    assign raw = {bus_request_n_i, bus_grant_n_i, bus_reset_n_i,
                  system_error_n_i, target_stop_n_i};

    // a change counts only once stages two and three agree
    always_comb
    begin
        s1_d   = raw;
        s2_d   = s1_q;
        s3_d   = s2_q;
        filt_d = filt_q;
        for (int i = 0; i < NSYNC; i++)
        begin
            if (s2_q[i] == s3_q[i])
            begin
                filt_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_q   <= {NSYNC{1'b1}};
            s2_q   <= {NSYNC{1'b1}};
            s3_q   <= {NSYNC{1'b1}};
            filt_q <= {NSYNC{1'b1}};
        end
        else
        begin
            s1_q   <= s1_d;
            s2_q   <= s2_d;
            s3_q   <= s3_d;
            filt_q <= filt_d;
        end
    end

    logic [1:0] req_in_n, gnt_in_n;
    logic       rst_in_n, serr_in_n, stop_in_n;
    assign {req_in_n, gnt_in_n, rst_in_n, serr_in_n, stop_in_n} = filt_q;

    // ready pin synchroniser kept separate, same three-stage rule
    logic [2:0] rdy_q, rdy_d;
    logic       rdy_filt_q, rdy_filt_d;

    always_comb
    begin
        rdy_d      = {rdy_q[1:0], target_ready_n_i};
        rdy_filt_d = (rdy_q[1] == rdy_q[2]) ? rdy_q[2] : rdy_filt_q;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdy_q      <= 3'h7;
            rdy_filt_q <= 1'b1;
        end
        else
        begin
            rdy_q      <= rdy_d;
            rdy_filt_q <= rdy_filt_d;
        end
    end

    // ------------------------------------------------------------
    // mode capture and bus reset sequencer
    // ------------------------------------------------------------
    pci_pin_pkg::seq_state_type state_q, state_d;
    pci_pin_pkg::bus_mode_type  mode_q, mode_d;
    logic [31:0]                cnt_q, cnt_d;
    logic                       warm_q, warm_d;
    logic                       rst_prev_q, rst_prev_d;

    always_comb
    begin
        state_d    = state_q;
        mode_d     = mode_q;
        cnt_d      = cnt_q;
        warm_d     = 1'b0;
        rst_prev_d = rst_in_n;
        unique case (state_q)
            pci_pin_pkg::ST_STRAP:
            begin
                // strap taken once after release, frozen thereafter
                if (mode_strap == 2'h2)
                    mode_d = pci_pin_pkg::MODE_SATELLITE;
                else if (mode_strap == 2'h1)
                    mode_d = pci_pin_pkg::MODE_HOST_EXT_ARB;
                else
                    mode_d = pci_pin_pkg::MODE_HOST_INT_ARB;
                // host always resets the bus on start
                state_d = (mode_strap == 2'h2) ? pci_pin_pkg::ST_RUN
                                               : pci_pin_pkg::ST_BUS_RESET;
                cnt_d   = 32'h0;
            end
            pci_pin_pkg::ST_BUS_RESET:
            begin
                cnt_d = cnt_q + 32'h1;
                if (cnt_q >= 32'(BUS_RESET_CYCLES - 1) && !core_bus_reset)
                    state_d = pci_pin_pkg::ST_RUN;
            end
            pci_pin_pkg::ST_RUN:
            begin
                if (mode_q != pci_pin_pkg::MODE_SATELLITE && core_bus_reset)
                begin
                    state_d = pci_pin_pkg::ST_BUS_RESET;
                    cnt_d   = 32'h0;
                end
                // falling edge of the received reset
                if (mode_q == pci_pin_pkg::MODE_SATELLITE
                    && rst_prev_q && !rst_in_n)
                    warm_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q    <= pci_pin_pkg::ST_STRAP;
            mode_q     <= pci_pin_pkg::RESET_MODE;
            cnt_q      <= 32'h0;
            warm_q     <= 1'b0;
            rst_prev_q <= 1'b1;
        end
        else
        begin
            state_q    <= state_d;
            mode_q     <= mode_d;
            cnt_q      <= cnt_d;
            warm_q     <= warm_d;
            rst_prev_q <= rst_prev_d;
        end
    end

    // ------------------------------------------------------------
    // registered pin drive
    // ------------------------------------------------------------
    logic [1:0] req_o_q, req_o_d, req_oe_q, req_oe_d;
    logic [1:0] gnt_o_q, gnt_o_d, gnt_oe_q, gnt_oe_d;
    logic       brst_oe_q, brst_oe_d;
    logic       serr_oe_q, serr_oe_d;
    logic       stop_oe_q, stop_oe_d, rdy_oe_q, rdy_oe_d;
    logic       stop_o_q, stop_o_d, rdy_o_q, rdy_o_d;
    logic       satellite, running;

    assign satellite = (mode_q == pci_pin_pkg::MODE_SATELLITE);
    assign running   = (state_q == pci_pin_pkg::ST_RUN);

    always_comb
    begin
        req_o_d  = 2'h3;
        req_oe_d = 2'h0;
        gnt_o_d  = 2'h3;
        gnt_oe_d = 2'h0;
        unique case (mode_q)
            pci_pin_pkg::MODE_HOST_INT_ARB:
            begin
                req_oe_d = 2'h0;
                gnt_o_d  = ~arb_grant;
                gnt_oe_d = {2{running}};
            end
            pci_pin_pkg::MODE_HOST_EXT_ARB:
            begin
                req_o_d  = {1'b1, ~(core_bus_req & running)};
                req_oe_d = {2{state_q != pci_pin_pkg::ST_STRAP}};
                gnt_o_d  = 2'h3;
                gnt_oe_d = 2'h2;
            end
            default:
            begin
                req_o_d  = {1'b1, ~(core_bus_req & running)};
                req_oe_d = {1'b0, state_q != pci_pin_pkg::ST_STRAP};
                gnt_o_d  = {~core_eeprom_select, 1'b1};
                gnt_oe_d = {state_q != pci_pin_pkg::ST_STRAP, 1'b0};
            end
        endcase
        // host drives reset low in the bus reset state, released otherwise
        // not in the strap cycle: the mode is not known there yet
        brst_oe_d = !satellite && (state_q == pci_pin_pkg::ST_BUS_RESET);
        // open drain: only ever pulls low
        serr_oe_d = core_target.sys_error && running;
        // target signals only while the device is the addressed target
        stop_o_d  = ~core_target.stop;
        rdy_o_d   = ~core_target.ready;
        stop_oe_d = core_target_sel && running;
        rdy_oe_d  = core_target_sel && running;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            req_o_q   <= 2'h3;
            req_oe_q  <= 2'h0;
            gnt_o_q   <= 2'h3;
            gnt_oe_q  <= 2'h0;
            brst_oe_q <= 1'b0;
            serr_oe_q <= 1'b0;
            stop_o_q  <= 1'b1;
            rdy_o_q   <= 1'b1;
            stop_oe_q <= 1'b0;
            rdy_oe_q  <= 1'b0;
        end
        else
        begin
            req_o_q   <= req_o_d;
            req_oe_q  <= req_oe_d;
            gnt_o_q   <= gnt_o_d;
            gnt_oe_q  <= gnt_oe_d;
            brst_oe_q <= brst_oe_d;
            serr_oe_q <= serr_oe_d;
            stop_o_q  <= stop_o_d;
            rdy_o_q   <= rdy_o_d;
            stop_oe_q <= stop_oe_d;
            rdy_oe_q  <= rdy_oe_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign bus_mode          = mode_q;
    assign bus_request_n_o   = req_o_q;
    assign bus_request_n_oe  = req_oe_q;
    assign bus_grant_n_o     = gnt_o_q;
    assign bus_grant_n_oe    = gnt_oe_q;
    assign bus_reset_n_o     = 1'b0;
    assign bus_reset_n_oe    = brst_oe_q;
    assign system_error_n_o  = 1'b0;
    assign system_error_n_oe = serr_oe_q;
    assign target_stop_n_o   = stop_o_q;
    assign target_stop_n_oe  = stop_oe_q;
    assign target_ready_n_o  = rdy_o_q;
    assign target_ready_n_oe = rdy_oe_q;
    // internal arbiter sees both request lines
    assign arb_request       = (mode_q == pci_pin_pkg::MODE_HOST_INT_ARB)
                               ? ~req_in_n : 2'h0;
    assign core_grant        = !satellite
        ? (mode_q == pci_pin_pkg::MODE_HOST_EXT_ARB) & ~gnt_in_n[0]
        : ~gnt_in_n[0];
    assign config_id_select  = satellite & ~req_in_n[1];
    assign warm_reset_req    = warm_q;
    assign system_error_seen = ~serr_in_n;
    assign bus_stop_seen     = ~stop_in_n;
    assign bus_ready_seen    = ~rdy_filt_q;

endmodule

`default_nettype wire

// ==== bench/pci_mode_pin_checker.sv ====
// Purpose: port assertions for the mode pin control block
// Assumes: one clock, rst_n asynchronous active low
// Notes:   attached to every instance by the bind at the foot
`timescale 1ns/1ps
`default_nettype none
module pci_mode_pin_checker #(
    parameter int BUS_RESET_CYCLES = 4
) (
    // clock and reset
    input wire logic                        core_clk,
    input wire logic                        rst_n,
    // core side
    input wire logic [1:0]                  bus_mode,
    input wire logic                        core_bus_req,
    input wire pci_pin_pkg::target_req_type core_target,
    input wire logic                        core_target_sel,
    input wire logic                        core_eeprom_select,
    input wire logic                        warm_reset_req,
    // pins
    input wire logic [1:0]                  bus_request_n_o,
    input wire logic [1:0]                  bus_request_n_oe,
    input wire logic [1:0]                  bus_grant_n_o,
    input wire logic [1:0]                  bus_grant_n_oe,
    input wire logic                        bus_reset_n_i,
    input wire logic                        bus_reset_n_oe,
    input wire logic                        system_error_n_o,
    input wire logic                        system_error_n_oe,
    input wire logic                        target_stop_n_o,
    input wire logic                        target_stop_n_oe,
    input wire logic                        target_ready_n_o,
    input wire logic                        target_ready_n_oe
);
    logic [1:0] since_q;
    int         run_q;
    logic       int_m;
    logic       ext_m;
    logic       sat_m;

    assign int_m = bus_mode == pci_pin_pkg::MODE_HOST_INT_ARB;
    assign ext_m = bus_mode == pci_pin_pkg::MODE_HOST_EXT_ARB;
    assign sat_m = bus_mode == pci_pin_pkg::MODE_SATELLITE;

    // mode settles one edge after release; pin drives lag one more
    always_ff @(posedge core_clk or negedge rst_n)
        if (!rst_n)
        begin
            since_q <= 2'h0;
            run_q   <= 0;
        end
        else
        begin
            since_q <= since_q[1] ? since_q : since_q + 2'h1;
            run_q   <= bus_reset_n_oe ? run_q + 1 : 0;
        end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_ext_reset;
        sat_m && $fell(bus_reset_n_i);
    endsequence
    sequence s_warm_pulse;
        ##[1:8] warm_reset_req ##1 !warm_reset_req;
    endsequence

    a_req_host_in:
        assert property (int_m |-> bus_request_n_oe == 2'h0)
        else $error("request pin driven with internal arbiter");
    a_req1_high:
        assert property (ext_m && since_q[1] |->
            bus_request_n_oe[1] && bus_request_n_o[1])
        else $error("request 1 not held high");
    // request and target pins are not pulled low while this device holds the bus in reset
    a_req0_drive:
        assert property (!int_m && since_q[1] && core_bus_req |=>
            bus_reset_n_oe
            || (bus_request_n_oe[0] && !bus_request_n_o[0]))
        else $error("request 0 not asserted");
    a_sat_no_reset:
        assert property (sat_m |-> !bus_reset_n_oe)
        else $error("bus reset driven in satellite mode");
    a_reset_len:
        assert property ($fell(bus_reset_n_oe) |-> run_q >= BUS_RESET_CYCLES)
        else $error("bus reset released too early");
    a_warm_start:
        assert property (s_ext_reset |-> s_warm_pulse)
        else $error("no warm reset pulse after bus reset");
    a_warm_only:
        assert property (warm_reset_req |-> sat_m ##1 !warm_reset_req)
        else $error("warm reset pulse out of place");
    a_serr_drive:
        assert property (core_target.sys_error |=>
            bus_reset_n_oe || (system_error_n_oe && !system_error_n_o))
        else $error("system error not driven");
    a_stop_drive:
        assert property (core_target_sel && core_target.stop |=>
            bus_reset_n_oe || (target_stop_n_oe && !target_stop_n_o))
        else $error("stop not driven");
    a_ready_drive:
        assert property (core_target_sel && core_target.ready |=>
            bus_reset_n_oe || (target_ready_n_oe && !target_ready_n_o))
        else $error("target ready not driven");
    a_grant_input:
        assert property (sat_m && since_q[1] |-> !bus_grant_n_oe[0])
        else $error("grant 0 driven in satellite mode");
    a_eeprom_sel:
        assert property (sat_m && since_q[1] && core_eeprom_select |=>
            bus_grant_n_oe[1] && !bus_grant_n_o[1])
        else $error("eeprom select not driven");
    a_mode_fixed:
        assert property (since_q[1] |-> $stable(bus_mode))
        else $error("mode changed after reset");
endmodule

bind pci_mode_pin_control pci_mode_pin_checker #(
    .BUS_RESET_CYCLES(BUS_RESET_CYCLES)
) pci_mode_pin_checker_i (
    .core_clk, .rst_n, .bus_mode, .core_bus_req, .core_target,
    .core_target_sel, .core_eeprom_select, .warm_reset_req,
    .bus_request_n_o, .bus_request_n_oe, .bus_grant_n_o, .bus_grant_n_oe,
    .bus_reset_n_i, .bus_reset_n_oe, .system_error_n_o, .system_error_n_oe,
    .target_stop_n_o, .target_stop_n_oe, .target_ready_n_o,
    .target_ready_n_oe
);
`default_nettype wire

// ==== bench/pci_agent_model.sv ====
// Purpose: other bus agents and an external arbiter facing the block
// Assumes: every line is pulled up; anyone may pull it low
// Notes:   line index 0-1 request, 2-3 grant, 4 reset, 5 error, 6-7 target
`timescale 1ns/1ps
`default_nettype none
module pci_agent_model (
    // clock and agent commands: request 1:0, reset, error, stop, ready
    input  wire logic                             core_clk,
    input  wire logic [5:0]                       agent_cmd,
    input  wire logic                             arbiter_on,
    input  wire logic [1:0]                       grant_delay,
    // device drives and resolved line levels
    input  wire pci_pin_pkg::pin_drive_type [7:0] dev_drv,
    output logic [7:0]                            wire_n
);
    logic [1:0] wait_q = 2'h0;
    logic       grant_q = 1'b0;
    logic [7:0] agent_lo;

    assign agent_lo = {agent_cmd[5:2], 1'b0, grant_q, agent_cmd[1:0]};
    always_comb
        for (int k = 0; k < 8; k++)
            wire_n[k] = !(agent_lo[k] || (dev_drv[k].oe && !dev_drv[k].o));

    // grant lags a request by a chosen delay, so slow arbiters are covered
    always_ff @(posedge core_clk)
        if (!arbiter_on || wire_n[0])
        begin
            wait_q  <= 2'h0;
            grant_q <= 1'b0;
        end
        else if (wait_q == grant_delay)
            grant_q <= 1'b1;
        else
            wait_q <= wait_q + 2'h1;
endmodule
`default_nettype wire

// ==== bench/test_pci_mode_pin_control.sv ====
// Purpose: self-checking bench for the mode pin control block
// Assumes: strap held through reset; inputs held until pins settle
// Notes:   short bus reset count keeps the run brief
`timescale 1ns/1ps
`default_nettype none
module test_pci_mode_pin_control;
    logic       core_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [1:0] mode_strap = 2'h0;
    logic [1:0] arb_grant = 2'h0;
    logic [1:0] grant_delay = 2'h0;
    logic [5:0] agent_cmd = 6'h0;
    logic       arbiter_on = 1'b0;
    logic       core_bus_req = 1'b0, core_bus_reset = 1'b0;
    logic       core_eeprom_select = 1'b0, core_target_sel = 1'b0;
    logic [1:0] bus_mode, arb_request, bus_request_n_o, bus_request_n_oe;
    logic [1:0] bus_grant_n_o, bus_grant_n_oe;
    logic       core_grant, config_id_select, warm_reset_req, bus_reset_n_o;
    logic       system_error_seen, bus_stop_seen, bus_ready_seen;
    logic       bus_reset_n_oe, system_error_n_o, system_error_n_oe;
    logic       target_stop_n_o, target_stop_n_oe;
    logic       target_ready_n_o, target_ready_n_oe;
    logic [7:0] wire_n, pull_lo;
    int         seed = 24, err_count = 0, compares = 0, warm_cnt = 0;
    pci_pin_pkg::pin_drive_type [7:0] dev_drv;
    pci_pin_pkg::target_req_type      core_target = 3'h0;

    always #2.5 core_clk = ~core_clk;

    assign dev_drv = {target_ready_n_o, target_ready_n_oe, target_stop_n_o,
        target_stop_n_oe, system_error_n_o, system_error_n_oe, bus_reset_n_o,
        bus_reset_n_oe, bus_grant_n_o[1], bus_grant_n_oe[1], bus_grant_n_o[0],
        bus_grant_n_oe[0], bus_request_n_o[1], bus_request_n_oe[1],
        bus_request_n_o[0], bus_request_n_oe[0]};
    always_comb
        for (int k = 0; k < 8; k++)
            pull_lo[k] = dev_drv[k].oe && !dev_drv[k].o;
    always @(posedge core_clk)
        if (warm_reset_req === 1'b1)
            warm_cnt <= warm_cnt + 1;

    pci_mode_pin_control #(
        .BUS_RESET_CYCLES(4)
    ) pci_mode_pin_control_i (
        .core_clk, .rst_n, .mode_strap, .bus_mode, .core_bus_req,
        .core_bus_reset, .core_target, .core_eeprom_select, .arb_request,
        .core_grant, .config_id_select, .warm_reset_req, .system_error_seen,
        .bus_stop_seen, .bus_ready_seen, .bus_request_n_o, .bus_request_n_oe,
        .bus_request_n_i(wire_n[1:0]), .bus_grant_n_i(wire_n[3:2]),
        .arb_grant, .bus_grant_n_o, .bus_grant_n_oe,
        .bus_reset_n_i(wire_n[4]), .bus_reset_n_o, .bus_reset_n_oe,
        .system_error_n_i(wire_n[5]), .system_error_n_o, .system_error_n_oe,
        .target_stop_n_i(wire_n[6]), .target_stop_n_o, .target_stop_n_oe,
        .target_ready_n_i(wire_n[7]), .target_ready_n_o, .target_ready_n_oe,
        .core_target_sel
    );
    pci_agent_model pci_agent_model_i (
        .core_clk, .agent_cmd, .arbiter_on, .grant_delay, .dev_drv, .wire_n
    );

    task automatic check_pins(input logic [7:0] exp, input logic [7:0] act);
        compares++;
        if (act !== exp)
        begin
            err_count++;
            $display("CHECK FAILED pins t=%0t exp=%h act=%h", $time, exp, act);
        end
    endtask

    task automatic check_core(input logic [7:0] exp, input logic [7:0] act);
        compares++;
        if (act !== exp)
        begin
            err_count++;
            $display("CHECK FAILED core t=%0t exp=%h act=%h", $time, exp, act);
        end
    endtask

    task automatic report_and_stop();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic do_reset(input int s);
        @(negedge core_clk);
        rst_n = 1'b0;
        mode_strap = s[1:0];
        {core_bus_req, core_bus_reset, core_eeprom_select} = 3'h0;
        {core_target_sel, core_target, arb_grant, agent_cmd} = 12'h000;
        arbiter_on = s == 1 || s == 2;
        repeat (12) @(negedge core_clk);
        check_pins(8'h00, pull_lo);
        check_core(8'h00, {5'h00, warm_reset_req, bus_mode});
        rst_n = 1'b1;
        repeat (3) @(negedge core_clk);
        check_pins(8'(s != 2), 8'(pull_lo[4]));
        repeat (13) @(negedge core_clk);
    endtask

    // inputs are held long enough for the pin synchronisers to agree
    task automatic step(input int m);
        int         r;
        logic       was_rst;
        logic [7:0] mk;
        logic       br;
        r = $random(seed);
        was_rst = agent_cmd[2];
        {core_bus_req, core_bus_reset, core_eeprom_select} = r[2:0];
        {core_target_sel, core_target, arb_grant} = r[8:3];
        {mode_strap, grant_delay} = r[12:9];
        agent_cmd = r[18:13] & {3'h7, m == 2, m != 1, m == 0};
        // a host bus reset stops the device pulling any other pin low
        br = m != 2 && core_bus_reset;
        warm_cnt = 0;
        repeat (12) @(negedge core_clk);
        check_core({6'h00, 2'(m)}, {6'h00, bus_mode});
        check_pins({core_target_sel & core_target.ready & !br,
            core_target_sel & core_target.stop & !br,
            core_target.sys_error & !br, br,
            m == 0 ? arb_grant & {2{!br}}
                   : {m == 2 && core_eeprom_select, 1'b0},
            1'b0, m != 0 && core_bus_req && !br}, pull_lo);
        mk = {4'h7, m == 2, m != 0, m == 0, m == 0};
        check_core({1'b0,
            core_target_sel & core_target.ready & !br | agent_cmd[5],
            core_target_sel & core_target.stop & !br | agent_cmd[4],
            core_target.sys_error & !br | agent_cmd[3], agent_cmd[1],
            core_bus_req & !br,
            agent_cmd[1:0]} & mk, {1'b0, bus_ready_seen, bus_stop_seen,
            system_error_seen, config_id_select, core_grant,
            arb_request} & mk);
        check_core(8'(m == 2 && !was_rst && agent_cmd[2]), 8'(warm_cnt));
    endtask

    initial
    begin
        for (int s = 0; s < 4; s++)
        begin
            do_reset(s);
            repeat (30)
                step(s == 3 ? 0 : s);
        end
        report_and_stop();
    end

    // run needs about 8 us; the margin covers slow grants
    initial
    begin
        #20us;
        err_count++;
        report_and_stop();
    end
endmodule
`default_nettype wire
